// File: rtl/jbs_pkg.sv
/*
 Shared constants and types of the boundary-scan test access port:
 instruction codes, identification code, controller states and pin groups.
 Assumes nothing of its surroundings; every other file except the one holding jbs_sync names it directly.
*/
`default_nettype none

package jbs_pkg;

   // ==========================================================
   // Instruction register
   localparam int         IR_W       = 4;
   localparam logic [3:0] IR_CAPTURE = 4'h1;
   localparam logic [3:0] OP_EXTEST  = 4'h0;
   localparam logic [3:0] OP_SAMPLE  = 4'h1;
   localparam logic [3:0] OP_IDCODE  = 4'h2;
   localparam logic [3:0] OP_CLAMP   = 4'h3;
   localparam logic [3:0] OP_INTEST  = 4'h4;
   localparam logic [3:0] OP_MAKER   = 4'h8;
   localparam logic [3:0] OP_BYPASS  = 4'hf;

   // ==========================================================
   // Identification code; the field values are arbitrary.
   localparam int          ID_W       = 32;
   localparam logic [3:0]  ID_VERSION = 4'h1;
   localparam logic [15:0] ID_PART    = 16'h7a5c;
   localparam logic [10:0] ID_MAKER   = 11'h2b3;
   localparam logic [31:0] ID_VALUE   = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};

   // ==========================================================
   // Private test register and default boundary sizes
   localparam int         PRIV_W       = 8;
   localparam logic [7:0] PRIV_CAPTURE = 8'ha5;
   localparam int         N_IN_DEF     = 8;
   localparam int         N_OUT_DEF    = 8;

   // ==========================================================
   // Controller states
   typedef enum logic [15:0] {
      TS_RESET    = 16'h0001,
      TS_IDLE     = 16'h0002,
      TS_SEL_DR   = 16'h0004,
      TS_CAP_DR   = 16'h0008,
      TS_SHIFT_DR = 16'h0010,
      TS_EXIT1_DR = 16'h0020,
      TS_PAUSE_DR = 16'h0040,
      TS_EXIT2_DR = 16'h0080,
      TS_UPD_DR   = 16'h0100,
      TS_SEL_IR   = 16'h0200,
      TS_CAP_IR   = 16'h0400,
      TS_SHIFT_IR = 16'h0800,
      TS_EXIT1_IR = 16'h1000,
      TS_PAUSE_IR = 16'h2000,
      TS_EXIT2_IR = 16'h4000,
      TS_UPD_IR   = 16'h8000
   } jbs_tap_state_type;

   typedef enum logic [3:0] {
      PATH_BYP = 4'h1,
      PATH_ID  = 4'h2,
      PATH_BSR = 4'h4,
      PATH_PRV = 4'h8
   } jbs_path_type;

   // ==========================================================
   // Pin groups
   typedef struct packed {
      logic tms;
      logic tdi;
   } jbs_jtag_in_type;

   typedef struct packed {
      logic tdo;
      logic tdo_oe;
   } jbs_jtag_out_type;

endpackage : jbs_pkg

`default_nettype wire

// File: rtl/jbs_sync.sv
/*
 Two-stage level synchroniser of parameter width.
 Assumes each bit is a level that stays put long enough to be seen.
*/
`timescale 1ns/1ns
`default_nettype none

module jbs_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } jbs_sync_reg_type;

   jbs_sync_reg_type r;
   jbs_sync_reg_type next_r;

   if (W < 1) begin : g_bad_w
      $error("jbs_sync: W must be at least 1");
   end

   always_comb begin
      next_r    = r;
      next_r.s1 = d;
      next_r.s2 = r.s1;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign q = r.s2;

endmodule : jbs_sync

`default_nettype wire

// File: rtl/jbs_tap_fsm.sv
/*
 Sixteen-state test access port controller, stepped by the test clock.
 Assumes the test reset is asynchronous and active low.
*/
`timescale 1ns/1ns
`default_nettype none

module jbs_tap_fsm (
   input  wire logic                 tck,
   input  wire logic                 trst_n,
   input  wire logic                 tms,
   output jbs_pkg::jbs_tap_state_type state
);

   typedef struct packed {
      jbs_pkg::jbs_tap_state_type st;
   } jbs_fsm_reg_type;

   jbs_fsm_reg_type r;
   jbs_fsm_reg_type next_r;

   // ==========================================================
   // Transitions
   // R2: standard transitions
   always_comb begin
      next_r = r;
      unique case (r.st)
         jbs_pkg::TS_RESET:
            next_r.st = tms ? jbs_pkg::TS_RESET : jbs_pkg::TS_IDLE;
         jbs_pkg::TS_IDLE:
            next_r.st = tms ? jbs_pkg::TS_SEL_DR : jbs_pkg::TS_IDLE;
         jbs_pkg::TS_SEL_DR:
            next_r.st = tms ? jbs_pkg::TS_SEL_IR : jbs_pkg::TS_CAP_DR;
         jbs_pkg::TS_CAP_DR:
            next_r.st = tms ? jbs_pkg::TS_EXIT1_DR : jbs_pkg::TS_SHIFT_DR;
         jbs_pkg::TS_SHIFT_DR:
            next_r.st = tms ? jbs_pkg::TS_EXIT1_DR : jbs_pkg::TS_SHIFT_DR;
         jbs_pkg::TS_EXIT1_DR:
            next_r.st = tms ? jbs_pkg::TS_UPD_DR : jbs_pkg::TS_PAUSE_DR;
         jbs_pkg::TS_PAUSE_DR:
            next_r.st = tms ? jbs_pkg::TS_EXIT2_DR : jbs_pkg::TS_PAUSE_DR;
         jbs_pkg::TS_EXIT2_DR:
            next_r.st = tms ? jbs_pkg::TS_UPD_DR : jbs_pkg::TS_SHIFT_DR;
         jbs_pkg::TS_UPD_DR:
            next_r.st = tms ? jbs_pkg::TS_SEL_DR : jbs_pkg::TS_IDLE;
         jbs_pkg::TS_SEL_IR:
            next_r.st = tms ? jbs_pkg::TS_RESET : jbs_pkg::TS_CAP_IR;
         jbs_pkg::TS_CAP_IR:
            next_r.st = tms ? jbs_pkg::TS_EXIT1_IR : jbs_pkg::TS_SHIFT_IR;
         jbs_pkg::TS_SHIFT_IR:
            next_r.st = tms ? jbs_pkg::TS_EXIT1_IR : jbs_pkg::TS_SHIFT_IR;
         jbs_pkg::TS_EXIT1_IR:
            next_r.st = tms ? jbs_pkg::TS_UPD_IR : jbs_pkg::TS_PAUSE_IR;
         jbs_pkg::TS_PAUSE_IR:
            next_r.st = tms ? jbs_pkg::TS_EXIT2_IR : jbs_pkg::TS_PAUSE_IR;
         jbs_pkg::TS_EXIT2_IR:
            next_r.st = tms ? jbs_pkg::TS_UPD_IR : jbs_pkg::TS_SHIFT_IR;
         jbs_pkg::TS_UPD_IR:
            next_r.st = tms ? jbs_pkg::TS_SEL_DR : jbs_pkg::TS_IDLE;
         // A corrupted one-hot code falls back to the safe reset state.
         default:
            next_r.st = jbs_pkg::TS_RESET;
      endcase
   end

   // R14: asynchronous test reset
   always_ff @(posedge tck or negedge trst_n) begin
      if (!trst_n) begin
         r <= '{st: jbs_pkg::TS_RESET};
      end else begin
         r <= next_r;
      end
   end

   assign state = r.st;

   // ==========================================================
   // Checks
   property p_five_tms;
      @(posedge tck) disable iff (!trst_n)
         tms [*5] |=> (r.st == jbs_pkg::TS_RESET);
   endproperty
   a_five_tms: assert property (p_five_tms) // R2
      else $error("five tms highs did not reach reset");

endmodule : jbs_tap_fsm

`default_nettype wire

// File: rtl/jbs_tap_top.sv
/*
 Boundary-scan test port: controller, instruction register, bypass,
 identification, private test and boundary registers, plus the pin muxes.
 Assumes tck is the tester's clock, unrelated to clk, and may stop
 between accesses; pin_in comes from pads and core_out from clk logic.
*/
// How it works
// R1: five dedicated pins: tms, tck, trst_n, tdi, tdo.
// R2: controller and sequencing follow the open standard.
// R3: bypass gives one-stage path tdi to tdo.
// R4: external test drives pins from boundary latches.
// R5: sample captures pins without disturbing function.
// R6: sample also preloads the boundary output latches.
// R7: clamp selects bypass while pins stay driven.
// R8: internal test feeds core from boundary cells.
// R9: one private maker test instruction is decoded.
// R10: identification code selects the identification register.
// R11: identification register loads code at capture.
// R12: identification register is 32 bits, three fields.
// R13: bit 31 nearest tdi, bit 0 out first.
// R14: trst_n low resets controller without clock.
// R15: reset state loads identification code instruction.
// R16: tester keeps controller reset in functional use.
// R17: four-bit opcodes, inputs nearest tdo, chosen consistently.
`timescale 1ns/1ns
`default_nettype none

module jbs_tap_top #(
   parameter int N_IN  = jbs_pkg::N_IN_DEF,
   parameter int N_OUT = jbs_pkg::N_OUT_DEF
) (
   input  wire logic               clk,
   input  wire logic               rst_n,
   input  wire logic               tck,
   input  wire logic               trst_n,
   input  wire jbs_pkg::jbs_jtag_in_type jtag_in,
   output jbs_pkg::jbs_jtag_out_type     jtag_out,
   input  wire logic [N_IN-1:0]    pin_in,
   output logic      [N_OUT-1:0]   pin_out,
   input  wire logic [N_OUT-1:0]   core_out,
   output logic      [N_IN-1:0]    core_in
);

   localparam int BW = N_IN + N_OUT;
   localparam int IW = jbs_pkg::IR_W;
   localparam int DW = jbs_pkg::ID_W;
   localparam int PW = jbs_pkg::PRIV_W;

   if (N_IN < 1 || N_OUT < 1) begin : g_bad_size
      $error("jbs_tap_top: N_IN and N_OUT must be at least 1");
   end

   // ==========================================================
   // State of each domain
   typedef struct packed {
      logic [IW-1:0] ir;
      logic [IW-1:0] ir_sh;
      logic          byp;
      logic [DW-1:0] idr;
      logic [BW-1:0] bsr;
      logic [BW-1:0] upd;
      logic [PW-1:0] priv;
      logic          drive;
      logic          feed;
   } jbs_tck_reg_type;

   typedef struct packed {
      logic tdo;
      logic tdo_oe;
   } jbs_neg_reg_type;

   typedef struct packed {
      logic [N_OUT-1:0] pin_out;
      logic [N_IN-1:0]  core_in;
   } jbs_clk_reg_type;

   jbs_tck_reg_type t;
   jbs_tck_reg_type next_t;
   jbs_neg_reg_type n;
   jbs_neg_reg_type next_n;
   jbs_clk_reg_type c;
   jbs_clk_reg_type next_c;

   jbs_pkg::jbs_tap_state_type st;
   jbs_pkg::jbs_path_type      path;
   logic                       tdi;
   logic                       dr_out;
   logic [N_IN-1:0]            in_t;
   logic [N_OUT-1:0]           out_t;
   logic [N_IN-1:0]            pin_c;
   logic [1:0]                 flag_c;
   logic [BW-1:0]              upd_c;

   assign tdi = jtag_in.tdi;

   // ==========================================================
   // Instruction decode
   // R17: opcode to data path
   function automatic jbs_pkg::jbs_path_type sel_path(
      input logic [IW-1:0] ir
   );
      unique case (ir)
         jbs_pkg::OP_EXTEST,
         jbs_pkg::OP_SAMPLE,
         jbs_pkg::OP_INTEST: sel_path = jbs_pkg::PATH_BSR;
         jbs_pkg::OP_IDCODE: sel_path = jbs_pkg::PATH_ID;
         jbs_pkg::OP_MAKER:  sel_path = jbs_pkg::PATH_PRV;
         // Bypass, clamp and every unused code take the one-bit path.
         default:            sel_path = jbs_pkg::PATH_BYP;
      endcase
   endfunction : sel_path

   function automatic logic drives_pins(input logic [IW-1:0] ir);
      drives_pins = (ir == jbs_pkg::OP_EXTEST) ||
                    (ir == jbs_pkg::OP_CLAMP) ||
                    (ir == jbs_pkg::OP_INTEST);
   endfunction : drives_pins

   // ==========================================================
   // Controller and crossings into the test clock domain
   jbs_tap_fsm u_fsm (
      .tck    (tck),
      .trst_n (trst_n),
      .tms    (jtag_in.tms),
      .state  (st)
   );

   jbs_sync #(.W(N_IN)) u_in_tck (
      .clk   (tck),
      .rst_n (trst_n),
      .d     (pin_in),
      .q     (in_t)
   );

   jbs_sync #(.W(N_OUT)) u_out_tck (
      .clk   (tck),
      .rst_n (trst_n),
      .d     (c.pin_out),
      .q     (out_t)
   );

   // ==========================================================
   // Test data registers, stepped on the rising test clock
   always_comb begin
      next_t = t;
      path   = sel_path(t.ir);
      if (st == jbs_pkg::TS_CAP_IR) begin
         next_t.ir_sh = jbs_pkg::IR_CAPTURE;
      end
      if (st == jbs_pkg::TS_SHIFT_IR) begin
         next_t.ir_sh = {tdi, t.ir_sh[IW-1:1]};
      end
      if (st == jbs_pkg::TS_UPD_IR) begin
         next_t.ir = t.ir_sh;
      end
      // R15: reset restores functional instruction
      if (st == jbs_pkg::TS_RESET) begin
         next_t.ir = jbs_pkg::OP_IDCODE;
      end
      if (st == jbs_pkg::TS_CAP_DR) begin
         unique case (path)
            jbs_pkg::PATH_BYP: next_t.byp = 1'b0;
            // R11 R12: load fixed code
            jbs_pkg::PATH_ID:  next_t.idr = jbs_pkg::ID_VALUE;
            // R5: capture pins and driven outputs
            jbs_pkg::PATH_BSR: next_t.bsr = {out_t, in_t};
            // R9: private register capture
            jbs_pkg::PATH_PRV: next_t.priv = jbs_pkg::PRIV_CAPTURE;
         endcase
      end
      if (st == jbs_pkg::TS_SHIFT_DR) begin
         unique case (path)
            // R3: single stage path
            jbs_pkg::PATH_BYP: next_t.byp = tdi;
            // R13: shift toward bit 0
            jbs_pkg::PATH_ID:  next_t.idr = {tdi, t.idr[DW-1:1]};
            jbs_pkg::PATH_BSR: next_t.bsr = {tdi, t.bsr[BW-1:1]};
            jbs_pkg::PATH_PRV: next_t.priv = {tdi, t.priv[PW-1:1]};
         endcase
      end
      // R6: update latches, also under sample
      if (st == jbs_pkg::TS_UPD_DR && path == jbs_pkg::PATH_BSR) begin
         next_t.upd = t.bsr;
      end
      // R4 R7 R8: mode flags follow the instruction
      next_t.drive = drives_pins(next_t.ir);
      next_t.feed  = (next_t.ir == jbs_pkg::OP_INTEST);
   end

   always_ff @(posedge tck or negedge trst_n) begin
      if (!trst_n) begin
         t    <= '0;
         t.ir <= jbs_pkg::OP_IDCODE;
      end else begin
         t <= next_t;
      end
   end

   // R10: selected register drives the serial output
   always_comb begin
      dr_out = t.byp;
      unique case (sel_path(t.ir))
         jbs_pkg::PATH_BYP: dr_out = t.byp;
         jbs_pkg::PATH_ID:  dr_out = t.idr[0];
         jbs_pkg::PATH_BSR: dr_out = t.bsr[0];
         jbs_pkg::PATH_PRV: dr_out = t.priv[0];
      endcase
   end

   // ==========================================================
   // Serial output, changed on the falling test clock
   always_comb begin
      next_n        = n;
      next_n.tdo_oe = (st == jbs_pkg::TS_SHIFT_IR) ||
                      (st == jbs_pkg::TS_SHIFT_DR);
      if (st == jbs_pkg::TS_SHIFT_IR) begin
         next_n.tdo = t.ir_sh[0];
      end else if (st == jbs_pkg::TS_SHIFT_DR) begin
         next_n.tdo = dr_out;
      end
   end

   // The falling edge gives the tester half a period of hold on tdo.
   always_ff @(negedge tck or negedge trst_n) begin
      if (!trst_n) begin
         n <= '0;
      end else begin
         n <= next_n;
      end
   end

   // R1: dedicated output pin and its enable
   assign jtag_out = '{tdo: n.tdo, tdo_oe: n.tdo_oe};

   // ==========================================================
   // Crossings into the system clock domain
   // The latches only change in update states, so a test program
   // must let a few clk periods pass before relying on the pins.
   jbs_sync #(.W(N_IN)) u_pin_clk (
      .clk   (clk),
      .rst_n (rst_n),
      .d     (pin_in),
      .q     (pin_c)
   );

   jbs_sync #(.W(2)) u_flag_clk (
      .clk   (clk),
      .rst_n (rst_n),
      .d     ({t.drive, t.feed}),
      .q     (flag_c)
   );

   jbs_sync #(.W(BW)) u_upd_clk (
      .clk   (clk),
      .rst_n (rst_n),
      .d     (t.upd),
      .q     (upd_c)
   );

   // ==========================================================
   // Pin and core muxes
   always_comb begin
      next_c = c;
      // R4 R7: boundary latches drive the pins
      next_c.pin_out = flag_c[1] ? upd_c[BW-1:N_IN] : core_out;
      // R8: boundary cells feed the core
      next_c.core_in = flag_c[0] ? upd_c[N_IN-1:0] : pin_c;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         c <= '0;
      end else begin
         c <= next_c;
      end
   end

   assign pin_out = c.pin_out;
   assign core_in = c.core_in;

   // ==========================================================
   // Checks
   property p_trst_async;
      @(posedge clk) disable iff (!rst_n)
         !trst_n |-> (st == jbs_pkg::TS_RESET);
   endproperty
   a_trst_async: assert property (p_trst_async) // R14
      else $error("controller not in reset while trst_n low");

   property p_reset_ir;
      @(posedge tck) disable iff (!trst_n)
         (st == jbs_pkg::TS_RESET) |=>
            (t.ir == jbs_pkg::OP_IDCODE) && !t.drive;
   endproperty
   a_reset_ir: assert property (p_reset_ir) // R15
      else $error("reset state did not load identification code");

   property p_bypass;
      @(posedge tck) disable iff (!trst_n)
         (st == jbs_pkg::TS_SHIFT_DR &&
          sel_path(t.ir) == jbs_pkg::PATH_BYP) ##1
         (st == jbs_pkg::TS_SHIFT_DR) |-> (dr_out == $past(tdi));
   endproperty
   a_bypass: assert property (p_bypass) // R3
      else $error("bypass path is not one stage");

   property p_id_capture;
      @(posedge tck) disable iff (!trst_n)
         (st == jbs_pkg::TS_CAP_DR && t.ir == jbs_pkg::OP_IDCODE) |=>
            (t.idr == jbs_pkg::ID_VALUE);
   endproperty
   a_id_capture: assert property (p_id_capture) // R11
      else $error("identification code not loaded at capture");

   property p_id_first;
      @(posedge tck) disable iff (!trst_n)
         (st == jbs_pkg::TS_CAP_DR && t.ir == jbs_pkg::OP_IDCODE) ##1
         (st == jbs_pkg::TS_SHIFT_DR) |-> (dr_out == 1'b1);
   endproperty
   a_id_first: assert property (p_id_first) // R10
      else $error("identification bit 0 not first on the path");

   property p_id_shift;
      @(posedge tck) disable iff (!trst_n)
         (st == jbs_pkg::TS_SHIFT_DR && t.ir == jbs_pkg::OP_IDCODE) |=>
            (t.idr[31] == $past(tdi)) &&
            (t.idr[30:0] == $past(t.idr[31:1]));
   endproperty
   a_id_shift: assert property (p_id_shift) // R13
      else $error("identification register shifts the wrong way");

   property p_sample;
      @(posedge tck) disable iff (!trst_n)
         (st == jbs_pkg::TS_CAP_DR && t.ir == jbs_pkg::OP_SAMPLE) |=>
            (t.bsr[N_IN-1:0] == $past(in_t)) && !t.drive;
   endproperty
   a_sample: assert property (p_sample) // R5
      else $error("sample did not capture the input pins");

   property p_preload;
      @(posedge tck) disable iff (!trst_n)
         (st == jbs_pkg::TS_UPD_DR && t.ir == jbs_pkg::OP_SAMPLE) |=>
            (t.upd == $past(t.bsr));
   endproperty
   a_preload: assert property (p_preload) // R6
      else $error("sample did not preload the latches");

   property p_clamp;
      @(posedge tck) disable iff (!trst_n)
         (st == jbs_pkg::TS_CAP_DR && t.ir == jbs_pkg::OP_CLAMP) |=>
            !t.byp && t.drive;
   endproperty
   a_clamp: assert property (p_clamp) // R7
      else $error("clamp did not select bypass with pins driven");

   property p_private;
      @(posedge tck) disable iff (!trst_n)
         (st == jbs_pkg::TS_CAP_DR && t.ir == jbs_pkg::OP_MAKER) |=>
            (t.priv == jbs_pkg::PRIV_CAPTURE);
   endproperty
   a_private: assert property (p_private) // R9
      else $error("private register capture wrong");

   property p_drive;
      @(posedge clk) disable iff (!rst_n)
         flag_c[1] |=> (c.pin_out == $past(upd_c[BW-1:N_IN]));
   endproperty
   a_drive: assert property (p_drive) // R4
      else $error("pins not driven from boundary latches");

   property p_intest;
      @(posedge clk) disable iff (!rst_n)
         flag_c[0] |=> (c.core_in == $past(upd_c[N_IN-1:0]));
   endproperty
   a_intest: assert property (p_intest) // R8
      else $error("core not fed from boundary cells");

endmodule : jbs_tap_top

`default_nettype wire

// File: testbench/jbs_tester.sv
/*
 Board tester model for the boundary-scan port: owns the test clock,
 test reset, mode select and data input, and reads the data output.
 Assumes the port samples on rising tck and updates tdo on falling tck.
*/
`timescale 1ns/1ns
`default_nettype none

module jbs_tester (
   output var logic                      tck,
   output var logic                      trst_n,
   output var jbs_pkg::jbs_jtag_in_type  jtag_in,
   input  wire jbs_pkg::jbs_jtag_out_type jtag_out
);
   logic oe_seen;

   // ==========================================================
   // reset held low
   // The reset falls after time zero, so that every process sees the edge.
   initial begin
      tck = 1'b0;
      trst_n = 1'b1;
      jtag_in = '0;
      oe_seen = 1'b0;
      #1;
      trst_n = 1'b0;
   end

   // ==========================================================
   // One 6 ns test clock cycle; the clock stands low between frames.
   task automatic step(input logic tms, input logic tdi, output logic tdo);
      jtag_in.tms = tms;
      jtag_in.tdi = tdi;
      #3;
      tdo = jtag_out.tdo;
      oe_seen = jtag_out.tdo_oe;
      tck = 1'b1;
      #3;
      tck = 1'b0;
   endtask : step

   task automatic to_idle();
      logic d;
      for (int i = 0; i < 5; i++) step(1'b1, 1'b0, d);
      step(1'b0, 1'b0, d);
   endtask : to_idle

   // scan from idle back to idle
   task automatic scan(input logic ir, input int n, input logic [63:0] din,
                       output logic [63:0] dout, output logic ok);
      logic d;
      dout = '0;
      ok = 1'b1;
      step(1'b1, 1'b0, d);
      if (ir) step(1'b1, 1'b0, d);
      step(1'b0, 1'b0, d);
      step(1'b0, 1'b0, d);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], d);
         dout[i] = d;
         ok = ok & oe_seen;
      end
      step(1'b1, 1'b0, d);
      step(1'b0, 1'b0, d);
      ok = ok & ~oe_seen;
   endtask : scan
endmodule : jbs_tester

`default_nettype wire

// File: testbench/tb_jbs_tap_top.sv
/*
 Self-checking bench of the boundary-scan port with a tester model.
 Assumes the package constants and the default boundary sizes.
*/
`timescale 1ns/1ns
`default_nettype none

module tb_jbs_tap_top;
   logic                      clk;
   logic                      rst_n;
   logic                      tck;
   logic                      trst_n;
   jbs_pkg::jbs_jtag_in_type  jtag_in;
   jbs_pkg::jbs_jtag_out_type jtag_out;
   logic [7:0]                pin_in;
   logic [7:0]                core_in;
   logic [7:0]                pin_out;
   logic [7:0]                core_out;
   logic [63:0]               so;
   logic                      ok;
   logic                      b;
   logic [15:0]               pre;
   logic [15:0]               pv;
   int                        error_cnt;
   int                        checked;
   int                        cycles;

   jbs_tap_top #(.N_IN(8), .N_OUT(8)) i_jbs_tap_top (.clk(clk),
      .rst_n(rst_n), .tck(tck), .trst_n(trst_n), .jtag_in(jtag_in),
      .jtag_out(jtag_out), .pin_in(pin_in), .pin_out(pin_out),
      .core_out(core_out), .core_in(core_in));
   jbs_tester i_jbs_tester (.tck(tck), .trst_n(trst_n), .jtag_in(jtag_in),
      .jtag_out(jtag_out));

   always #10 clk = ~clk;

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic test_done();
      $display("errors=%0d checks=%0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : test_done

   task automatic w(input int n);
      repeat (n) @(negedge clk);
   endtask : w

   task automatic ld(input logic [3:0] op);
      i_jbs_tester.scan(1'b1, 4, {60'h0, op}, so, ok);
      check(so[3:0], jbs_pkg::IR_CAPTURE);
      check(ok, 1'b1);
   endtask : ld

   // Model of the one-stage path: a queue primed with the captured zero.
   task automatic byp();
      bit          q[$];
      logic [63:0] exp;
      pv = 16'($urandom);
      q = {1'b0};
      exp = '0;
      for (int i = 0; i < 17; i++) begin
         q.push_back(i < 16 ? pv[i] : 1'b0);
         exp[i] = q.pop_front();
      end
      i_jbs_tester.scan(1'b0, 17, {48'h0, pv}, so, ok);
      check(so[16:0], exp[16:0]);
      check(ok, 1'b1);
   endtask : byp

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         test_done();
      end
   end

   initial begin
      clk = 1'b0;
      rst_n = 1'b1;
      pin_in = '0;
      core_out = '0;
      void'($urandom(76974));
      #1;
      rst_n = 1'b0;
      repeat (4) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      i_jbs_tester.trst_n = 1'b1;
      i_jbs_tester.to_idle();
      i_jbs_tester.scan(1'b0, 32, 64'h0, so, ok);
      check(so[31:0], jbs_pkg::ID_VALUE);
      check(ok, 1'b1);
      ld(4'hf);
      byp();
      ld(4'h5);
      byp();
      w(1);
      pin_in = 8'($urandom);
      core_out = 8'($urandom);
      pre = 16'($urandom);
      w(4);
      ld(jbs_pkg::OP_SAMPLE);
      i_jbs_tester.scan(1'b0, 16, {48'h0, pre}, so, ok);
      check(so[15:0], {core_out, pin_in});
      w(4);
      check(pin_out, core_out);
      check(core_in, pin_in);
      ld(jbs_pkg::OP_EXTEST);
      w(4);
      check(pin_out, pre[15:8]);
      check(core_in, pin_in);
      ld(jbs_pkg::OP_CLAMP);
      byp();
      w(4);
      check(pin_out, pre[15:8]);
      ld(jbs_pkg::OP_MAKER);
      i_jbs_tester.scan(1'b0, 8, 64'h0, so, ok);
      check(so[7:0], jbs_pkg::PRIV_CAPTURE);
      ld(jbs_pkg::OP_INTEST);
      w(4);
      check(core_in, pre[7:0]);
      i_jbs_tester.trst_n = 1'b0;
      w(4);
      check(pin_out, core_out);
      check(core_in, pin_in);
      check(jtag_out.tdo_oe, 1'b0);
      i_jbs_tester.trst_n = 1'b1;
      i_jbs_tester.step(1'b0, 1'b0, b);
      i_jbs_tester.scan(1'b0, 32, 64'h0, so, ok);
      check(so[31:0], jbs_pkg::ID_VALUE);
      test_done();
   end
endmodule : tb_jbs_tap_top

`default_nettype wire
